//--- pkg/sense_trig_pkg.sv
// Purpose: Constants and types shared by the sense-sample trigger generator
// Assumes: System clock of 100 MHz, Avalon-MM register access with 32-bit data
// Notes: Times are kept in nanoseconds and converted to clock counts here
package sense_trig_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // Fallback square wave used when the PWM clock is lost
    localparam int FALLBACK_PERIOD_NS = 6500000;
    localparam int FALLBACK_HALF_CYC = FALLBACK_PERIOD_NS / 2 / CLK_PERIOD_NS;
    // High pulse at PWM counter overflow when running at full duty
    localparam int OVF_PULSE_NS = 100000;
    localparam int OVF_PULSE_CYC = OVF_PULSE_NS / CLK_PERIOD_NS;
    // Blanking after a source change or offset toggle: turn-on delay plus settling
    localparam int TURN_ON_DLY_NS = 10000;
    localparam int SENSE_SETTLE_NS = 10000;
    localparam int BLANK_CYC = (TURN_ON_DLY_NS + SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Voltage mode: PWM clock divided by 1024, half period in PWM clock ticks
    localparam int VOLT_DIV = 1024;
    localparam int VOLT_HALF_TICKS = VOLT_DIV / 2;

    // Register map (byte addresses, compared directly with the bus address)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [2:0] CTRL_SEL_LSB = 3'h0;
    localparam logic [2:0] CTRL_STYLE_LSB = 3'h3;
    localparam logic [2:0] CTRL_ACM_BIT = 3'h5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // Source codes at or above this value select a voltage signal
    localparam logic [2:0] FIRST_VOLT_SRC = 3'h4;

    typedef enum logic [1:0] {
        STYLE_OFF = 2'h0,
        STYLE_VALID = 2'h1,
        STYLE_WAIT_NEXT_CYCLE = 2'h2,
        STYLE_HALF_PULSE = 2'h3
    } trig_style_t;

    typedef enum logic [3:0] {
        MODE_IDLE = 4'h1,
        MODE_CURRENT = 4'h2,
        MODE_VOLTAGE = 4'h4,
        MODE_FALLBACK = 4'h8
    } trig_mode_t;

    // Status of the selected output channel and the PWM engine
    typedef struct packed {
        logic normal_mode;
        logic pwm_on;
        logic cycle_start;
        logic pwm_clk_tick;
        logic full_duty;
        logic pwm_clk_fail;
        logic high_overcurrent_window;
        logic output_fault;
        logic output_enable;
    } pwm_status_t;
endpackage

//--- src/sense_sample_sync_gen.sv
// Purpose: Open-drain sampling trigger telling an external ADC when the sense pin is valid
// Assumes: PWM status inputs are synchronous to CLK_SYS_I; one Avalon-MM slave
// Notes: The pin level is registered; the open-drain driver only ever pulls low
// Behaviour
// RULE_01: Trigger activity only in Normal mode, otherwise pin released.
// RULE_02: Pin is open drain, only pulled low, pull-up gives high.
// RULE_03: Source select picks current-sense or voltage behaviour.
// RULE_04: Style 00 keeps the trigger released at all times; code: only in current mode, not in voltage or fallback mode.
// RULE_05: Style 01 low while sense valid, high while source switching.
// RULE_06: Style 10 like 01, but high after source change until next PWM cycle.
// RULE_07: Style 11 pulses low from sense-pulse midpoint to its end.
// RULE_08: Style 11 high from a source switch until the next midpoint.
// RULE_09: Current mode suppresses trigger in overcurrent window and PWM off phase.
// RULE_10: Fixed blanking after any source change or offset-mode toggle.
// RULE_11: Current mode with PWM clock lost: 50% square wave, 6.5 ms period.
// RULE_12: Full duty in styles 10/11: low, with 100 us high pulse per overflow.
// RULE_13: After an output fault no current triggers until output re-enabled.
// RULE_14: Voltage mode: 50% square wave at PWM clock divided by 1024.
// RULE_15: Voltage mode with PWM clock lost: 50% square wave, 6.5 ms.
// RULE_16: Alternating offset mode flips offset sign on each trigger rising edge.
// RULE_17: Controller converts only while trigger is low.
`timescale 1ns/10ps
module sense_sample_sync_gen
    import sense_trig_pkg::*;
#(
    parameter int FB_HALF_CYC = FALLBACK_HALF_CYC,
    parameter int PULSE_CYC = OVF_PULSE_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire pwm_status_t PWM_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic TRIG_I,
    output logic TRIG_O,
    output logic TRIG_OE_O,
    output logic OFFSET_SIGN_O
);
    logic [2:0] sense_source_select_ff;
    trig_style_t style_ff;
    logic alternating_offset_mode_ff;
    logic ack_ff;
    logic wr_ctrl;
    logic src_change;
    logic [11:0] blank_cnt_ff;
    logic blanking;
    logic wait_cycle_ff;
    logic wait_mid_ff;
    logic fault_hold_ff;
    logic enable_d_ff;
    logic [19:0] fb_cnt_ff;
    logic fb_sq_ff;
    logic [8:0] volt_cnt_ff;
    logic volt_sq_ff;
    logic [15:0] pulse_cnt_ff;
    logic [15:0] on_cnt_ff;
    logic [15:0] last_len_ff;
    logic on_d_ff;
    logic trig_low_ff;
    logic nxt_trig_low;
    logic sense_valid;
    logic at_mid;
    logic mid_hit;
    trig_mode_t mode_ff;
    trig_mode_t nxt_mode;

    // Saturating counter step, so a long on phase cannot wrap to a false midpoint
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // Bus handshake: one wait cycle, answer on the second cycle of a request
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_ff;
    assign wr_ctrl = AVS_WRITE_I & ack_ff & (AVS_ADDRESS_I == CTRL_OFS);
    assign src_change = wr_ctrl &
        (AVS_WRITEDATA_I[CTRL_SEL_LSB +: 3] != sense_source_select_ff);

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            ack_ff <= 1'b0;
            AVS_READDATA_O <= 32'h00000000;
        end else if (CE_I) begin
            ack_ff <= (AVS_READ_I | AVS_WRITE_I) & ~ack_ff;
            if (AVS_READ_I & ~ack_ff) begin
                unique case (AVS_ADDRESS_I)
                    CTRL_OFS: AVS_READDATA_O <= {26'h0000000, alternating_offset_mode_ff,
                        style_ff, sense_source_select_ff};
                    STATUS_OFS: AVS_READDATA_O <= {26'h0000000, mode_ff, OFFSET_SIGN_O, trig_low_ff};
                    default: AVS_READDATA_O <= 32'h00000000; // Unmapped reads as zero
                endcase
            end
        end
    end

    // Control register: source, trigger style and alternating offset mode
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            {alternating_offset_mode_ff, style_ff, sense_source_select_ff} <= CTRL_RESET;
        end else if (CE_I && wr_ctrl) begin
            sense_source_select_ff <= AVS_WRITEDATA_I[CTRL_SEL_LSB +: 3];
            style_ff <= trig_style_t'(AVS_WRITEDATA_I[CTRL_STYLE_LSB +: 2]);
            alternating_offset_mode_ff <= AVS_WRITEDATA_I[CTRL_ACM_BIT];
        end
    end

    // Operating mode; in Normal mode the fallback clock takes over whenever the PWM clock is lost
    always_comb begin
        if (!PWM_I.normal_mode) begin
            nxt_mode = MODE_IDLE; // [RULE_01]
        end else if (PWM_I.pwm_clk_fail) begin
            nxt_mode = MODE_FALLBACK; // [RULE_11] [RULE_15]
        end else if (sense_source_select_ff >= FIRST_VOLT_SRC) begin
            nxt_mode = MODE_VOLTAGE; // [RULE_03]
        end else begin
            nxt_mode = MODE_CURRENT; // [RULE_03]
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            mode_ff <= MODE_IDLE;
        end else if (CE_I) begin
            mode_ff <= nxt_mode;
        end
    end

    // Blanking timer, restarted by a source change or an offset sign flip
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            blank_cnt_ff <= 12'h000;
        end else if (CE_I) begin
            if (src_change || (alternating_offset_mode_ff && trig_low_ff && !nxt_trig_low)) begin
                blank_cnt_ff <= 12'(BLANK_CYC); // [RULE_10]
            end else if (blank_cnt_ff != 12'h000) begin
                blank_cnt_ff <= blank_cnt_ff - 12'h001;
            end
        end
    end
    assign blanking = (blank_cnt_ff != 12'h000);

    // Waits armed by a source change: next PWM cycle, or next fresh midpoint
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            wait_cycle_ff <= 1'b0;
            wait_mid_ff <= 1'b0;
        end else if (CE_I) begin
            if (src_change) begin
                wait_cycle_ff <= 1'b1; // [RULE_06]
            end else if (PWM_I.cycle_start) begin
                wait_cycle_ff <= 1'b0;
            end
            if (src_change) begin
                wait_mid_ff <= 1'b1; // [RULE_08]
            end else if (mid_hit && !blanking) begin
                wait_mid_ff <= 1'b0;
            end
        end
    end

    // Fault latch; a new fault wins over the re-enable seen in the same cycle
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            fault_hold_ff <= 1'b0;
            enable_d_ff <= 1'b0;
        end else if (CE_I) begin
            enable_d_ff <= PWM_I.output_enable;
            if (PWM_I.output_fault) begin
                fault_hold_ff <= 1'b1; // [RULE_13]
            end else if (PWM_I.output_enable && !enable_d_ff) begin
                fault_hold_ff <= 1'b0;
            end
        end
    end

    // Fixed-period square wave from the system clock for a lost PWM clock
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            fb_cnt_ff <= 20'h00000;
            fb_sq_ff <= 1'b1;
        end else if (CE_I) begin
            if (fb_cnt_ff >= 20'(FB_HALF_CYC - 1)) begin
                fb_cnt_ff <= 20'h00000;
                fb_sq_ff <= ~fb_sq_ff; // [RULE_11] [RULE_15]
            end else begin
                fb_cnt_ff <= fb_cnt_ff + 20'h00001;
            end
        end
    end

    // Square wave at the slowest prescaler rate, counted in PWM clock ticks
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            volt_cnt_ff <= 9'h000;
            volt_sq_ff <= 1'b1;
        end else if (CE_I && PWM_I.pwm_clk_tick) begin
            if (volt_cnt_ff == 9'(VOLT_HALF_TICKS - 1)) begin
                volt_cnt_ff <= 9'h000;
                volt_sq_ff <= ~volt_sq_ff; // [RULE_14]
            end else begin
                volt_cnt_ff <= volt_cnt_ff + 9'h001;
            end
        end
    end

    // Overflow pulse timer for full-duty operation
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            pulse_cnt_ff <= 16'h0000;
        end else if (CE_I) begin
            if (PWM_I.cycle_start) begin
                pulse_cnt_ff <= 16'(PULSE_CYC); // [RULE_12]
            end else if (pulse_cnt_ff != 16'h0000) begin
                pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
            end
        end
    end

    // On-phase length of the last pulse sets the midpoint of the present one
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            on_cnt_ff <= 16'h0000;
            last_len_ff <= 16'h0000;
            on_d_ff <= 1'b0;
        end else if (CE_I) begin
            on_d_ff <= PWM_I.pwm_on;
            if (PWM_I.pwm_on) begin
                on_cnt_ff <= sat_inc(on_cnt_ff);
            end else begin
                on_cnt_ff <= 16'h0000;
            end
            if (on_d_ff && !PWM_I.pwm_on) begin
                last_len_ff <= on_cnt_ff;
            end
        end
    end
    // Limitation: the first pulse after start-up has no reference, so mid is at once
    assign at_mid = PWM_I.pwm_on && (on_cnt_ff >= {1'b0, last_len_ff[15:1]});
    assign mid_hit = PWM_I.pwm_on && (on_cnt_ff == {1'b0, last_len_ff[15:1]});

    // Sense output counts as valid only in the on phase outside all suppressions
    assign sense_valid = PWM_I.pwm_on && !PWM_I.high_overcurrent_window && // [RULE_09]
        !fault_hold_ff && !blanking; // [RULE_13] [RULE_10]

    // Trigger level selection; true means the pin is pulled low
    always_comb begin
        nxt_trig_low = 1'b0;
        unique case (nxt_mode)
            MODE_IDLE: nxt_trig_low = 1'b0; // [RULE_01]
            MODE_FALLBACK: nxt_trig_low = !fb_sq_ff;
            MODE_VOLTAGE: nxt_trig_low = !volt_sq_ff;
            MODE_CURRENT: begin
                unique case (style_ff)
                    STYLE_OFF: nxt_trig_low = 1'b0; // [RULE_04]
                    STYLE_VALID: nxt_trig_low = sense_valid; // [RULE_05]
                    STYLE_WAIT_NEXT_CYCLE: begin
                        if (PWM_I.full_duty && !fault_hold_ff) begin
                            nxt_trig_low = (pulse_cnt_ff == 16'h0000); // [RULE_12]
                        end else begin
                            nxt_trig_low = sense_valid && !wait_cycle_ff; // [RULE_06]
                        end
                    end
                    STYLE_HALF_PULSE: begin
                        if (PWM_I.full_duty && !fault_hold_ff) begin
                            nxt_trig_low = (pulse_cnt_ff == 16'h0000); // [RULE_12]
                        end else begin
                            nxt_trig_low = sense_valid && at_mid && !wait_mid_ff; // [RULE_07] [RULE_08]
                        end
                    end
                endcase
            end
        endcase
    end

    // Pin and offset sign registers; the pin is only ever driven low
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            trig_low_ff <= 1'b0;
            OFFSET_SIGN_O <= 1'b0;
        end else if (CE_I) begin
            trig_low_ff <= nxt_trig_low;
            if (alternating_offset_mode_ff && trig_low_ff && !nxt_trig_low) begin
                OFFSET_SIGN_O <= ~OFFSET_SIGN_O; // [RULE_16]
            end
        end
    end
    assign TRIG_O = 1'b0; // [RULE_02]
    assign TRIG_OE_O = trig_low_ff; // [RULE_02]

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    idle_released_a: assert property (CE_I && !PWM_I.normal_mode |=> !TRIG_OE_O) // [RULE_01]
        else $error("Trigger driven outside normal mode");
    drive_low_only_a: assert property (TRIG_OE_O |-> !TRIG_O) // [RULE_02]
        else $error("Trigger pin driven high");
    style_off_a: assert property (CE_I && nxt_mode == MODE_CURRENT // [RULE_04]
        && style_ff == STYLE_OFF |=> !TRIG_OE_O)
        else $error("Trigger active in off style");
    valid_follow_a: assert property (CE_I && nxt_mode == MODE_CURRENT && style_ff == STYLE_VALID // [RULE_05]
        |=> TRIG_OE_O == $past(sense_valid))
        else $error("Valid style does not follow sense validity");
    wait_cycle_a: assert property (CE_I && src_change && style_ff == STYLE_WAIT_NEXT_CYCLE // [RULE_06]
        && !PWM_I.cycle_start |=> wait_cycle_ff)
        else $error("Source change did not arm cycle wait");
    suppress_oc_a: assert property (CE_I && nxt_mode == MODE_CURRENT && style_ff != STYLE_OFF // [RULE_09]
        && !PWM_I.full_duty && (PWM_I.high_overcurrent_window || !PWM_I.pwm_on) |=> !TRIG_OE_O)
        else $error("Trigger during overcurrent window or off phase");
    blank_len_a: assert property (CE_I && src_change |=> blank_cnt_ff == 12'(BLANK_CYC)) // [RULE_10]
        else $error("Blanking not started at source change");
    fault_hold_a: assert property (CE_I && PWM_I.output_fault |=> fault_hold_ff) // [RULE_13]
        else $error("Fault did not block triggers");
    // The flip is decided by the mode bit one cycle back, when the pin level was computed
    offset_flip_a: assert property ($past(alternating_offset_mode_ff) && $fell(TRIG_OE_O) // [RULE_16]
        |-> OFFSET_SIGN_O != $past(OFFSET_SIGN_O))
        else $error("Offset sign not flipped on trigger rise");
    volt_square_a: assert property (CE_I && nxt_mode == MODE_VOLTAGE |=> TRIG_OE_O == !$past(volt_sq_ff)) // [RULE_14]
        else $error("Voltage mode square wave wrong");
    fallback_a: assert property (CE_I && nxt_mode == MODE_FALLBACK |=> TRIG_OE_O == !$past(fb_sq_ff)) // [RULE_11]
        else $error("Fallback square wave wrong");

    valid_pulse_c: cover property (style_ff == STYLE_VALID && $rose(TRIG_OE_O));
    half_pulse_c: cover property (style_ff == STYLE_HALF_PULSE && $rose(TRIG_OE_O));
    full_duty_c: cover property (PWM_I.full_duty && $fell(TRIG_OE_O));
    fallback_c: cover property (mode_ff == MODE_FALLBACK && $rose(TRIG_OE_O));
endmodule

//--- verif/adc_sampler_model.sv
// Purpose: Behavioural model of the controller ADC that samples the analog sense pin
// Assumes: Trigger pin resolved here from the open-drain drive and an external pull-up
// Notes: Counts conversions so the bench can see that sampling followed a low trigger
`timescale 1ns/10ps
module adc_sampler_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic trig_o_i,
    input wire logic trig_oe_i,
    output logic pin_level_o,
    output logic [15:0] conv_count_o
);
    logic pin_prev_ff;
    logic [15:0] conv_count_ff;

    // Pull-up wins whenever the device releases the pin
    assign pin_level_o = trig_oe_i ? trig_o_i : 1'b1;
    assign conv_count_o = conv_count_ff;

    // A conversion starts only when the pin has just gone low; high means invalid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev_ff <= 1'b1;
            conv_count_ff <= 16'h0000;
        end else begin
            pin_prev_ff <= pin_level_o;
            if (pin_prev_ff && !pin_level_o) begin
                conv_count_ff <= conv_count_ff + 16'h0001;
            end
        end
    end
endmodule

//--- verif/sense_sample_sync_gen_tb.sv
// Purpose: Self-checking bench for the sense-sample trigger generator
// Assumes: Shortened fallback half period and overflow pulse via parameters
// Notes: Bus tasks hold each request until waitrequest is seen low at an edge
`timescale 1ns/10ps
module sense_sample_sync_gen_tb;
    import sense_trig_pkg::*;
    localparam int FB_HALF = 50;
    localparam int PULSE = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pwm_status_t pwm = '0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ce = 1'b1;
    logic trig_pin, trig_drv, trig_oe, offset_sign;
    logic [15:0] conv_count;
    logic [31:0] rd;
    int n_errors = 0;
    int total_checks = 0;
    int half;

    // Clock of 100 MHz
    always #5 clk = ~clk;

    sense_sample_sync_gen #(.FB_HALF_CYC(FB_HALF), .PULSE_CYC(PULSE)) DUT (
        .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .PWM_I(pwm),
        .AVS_ADDRESS_I(avs_address), .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
        .AVS_WRITEDATA_I(avs_writedata), .AVS_READDATA_O(avs_readdata),
        .AVS_WAITREQUEST_O(avs_waitrequest), .TRIG_I(trig_pin), .TRIG_O(trig_drv),
        .TRIG_OE_O(trig_oe), .OFFSET_SIGN_O(offset_sign)
    );

    adc_sampler_model adc (
        .clk_i(clk), .rst_i(rst), .trig_o_i(trig_drv), .trig_oe_i(trig_oe),
        .pin_level_o(trig_pin), .conv_count_o(conv_count)
    );

    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Let n edges pass, then look after their updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One bus cycle; called just after an edge, waits for waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check(32'h1, 32'h0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        #1;
    endtask

    // Half period of the trigger: skip to one change, then count to the next
    task automatic measure();
        logic v;
        int n;
        n = 0;
        v = trig_oe;
        while (trig_oe === v && n < 5000) begin
            tick(1);
            n++;
        end
        v = trig_oe;
        half = 0;
        while (trig_oe === v && half < 5000) begin
            tick(1);
            half++;
        end
    endtask

    // Settings change goes in, then the blanking interval is allowed to pass
    task automatic set_ctrl(input logic [31:0] v);
        bus(1'b1, CTRL_OFS, v);
        tick(BLANK_CYC + 50);
    endtask

    initial begin
        pwm.normal_mode <= 1'b1;
        pwm.output_enable <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        pwm.pwm_on <= 1'b1;
        tick(2);
        bus(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        check(rd[0], 1'b0);
        check(trig_oe, 1'b0);
        // Unmapped words and the status word ignore writes
        bus(1'b1, 4'hC, 32'hFFFFFFFF);
        bus(1'b0, 4'hC, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, STATUS_OFS, 32'hFFFFFFFF);
        bus(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        // Valid style on current channel 1
        set_ctrl(32'h09);
        check(trig_oe, 1'b1);
        check(trig_drv, 1'b0);
        bus(1'b0, STATUS_OFS, 32'h0);
        check(rd[5:0], 6'h09);
        pwm.high_overcurrent_window <= 1'b1;
        tick(3);
        check(trig_oe, 1'b0);
        pwm.high_overcurrent_window <= 1'b0;
        tick(3);
        check(trig_oe, 1'b1);
        pwm.pwm_on <= 1'b0;
        tick(3);
        check(trig_oe, 1'b0);
        check(conv_count != 16'h0, 1'b1);
        pwm.pwm_on <= 1'b1;
        pwm.normal_mode <= 1'b0;
        tick(3);
        check(trig_oe, 1'b0);
        pwm.normal_mode <= 1'b1;
        tick(3);
        check(trig_oe, 1'b1);
        // Clock enable low freezes the pin even though the on phase ends
        ce <= 1'b0;
        pwm.pwm_on <= 1'b0;
        tick(3);
        check(trig_oe, 1'b1);
        pwm.pwm_on <= 1'b1;
        ce <= 1'b1;
        tick(3);
        check(trig_oe, 1'b1);
        pwm.output_fault <= 1'b1;
        tick(1);
        pwm.output_fault <= 1'b0;
        tick(5);
        check(trig_oe, 1'b0);
        pwm.output_enable <= 1'b0;
        tick(1);
        pwm.output_enable <= 1'b1;
        tick(3);
        check(trig_oe, 1'b1);
        // Alternating offset: sign flips as the pin rises, then blanking restarts
        set_ctrl(32'h29);
        check(trig_oe, 1'b1);
        half = int'(offset_sign);
        pwm.pwm_on <= 1'b0;
        tick(3);
        check(offset_sign, !half[0]);
        pwm.pwm_on <= 1'b1;
        tick(3);
        check(trig_oe, 1'b0);
        // Wait-next-cycle style on channel 2
        set_ctrl(32'h12);
        check(trig_oe, 1'b0);
        pwm.cycle_start <= 1'b1;
        tick(1);
        pwm.cycle_start <= 1'b0;
        tick(3);
        check(trig_oe, 1'b1);
        // Full duty: high pulse of PULSE cycles at each overflow
        pwm.full_duty <= 1'b1;
        pwm.cycle_start <= 1'b1;
        tick(1);
        pwm.cycle_start <= 1'b0;
        tick(3);
        check(trig_oe, 1'b0);
        tick(PULSE + 2);
        check(trig_oe, 1'b1);
        pwm.full_duty <= 1'b0;
        // Half-pulse style on channel 3: the source switch arms the midpoint wait
        pwm.pwm_on <= 1'b0;
        set_ctrl(32'h1B);
        pwm.pwm_on <= 1'b1;
        tick(40);
        pwm.pwm_on <= 1'b0;
        tick(10);
        pwm.pwm_on <= 1'b1;
        tick(10);
        check(trig_oe, 1'b0);
        tick(20);
        check(trig_oe, 1'b1);
        pwm.pwm_on <= 1'b0;
        tick(3);
        check(trig_oe, 1'b0);
        // Voltage source: PWM clock divided by 1024
        pwm.pwm_clk_tick <= 1'b1;
        set_ctrl(32'h0C);
        bus(1'b0, STATUS_OFS, 32'h0);
        check(rd[5:2], 4'h4);
        measure();
        measure();
        check(half, VOLT_HALF_TICKS);
        // PWM clock lost in both modes
        pwm.pwm_clk_fail <= 1'b1;
        measure();
        measure();
        check(half, FB_HALF);
        set_ctrl(32'h09);
        bus(1'b0, STATUS_OFS, 32'h0);
        check(rd[5:2], 4'h8);
        measure();
        measure();
        check(half, FB_HALF);
        // Reset in mid-run: held for three edges so no false edge follows it
        pwm.pwm_clk_fail <= 1'b0;
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        tick(2);
        check(trig_oe, 1'b0);
        check(offset_sign, 1'b0);
        bus(1'b0, CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #800000;
        n_errors++;
        complete_run();
    end
endmodule
